/* File: logic/hdc_defines.vh */
// Constants for the holdover DAC control block.
// Assumes 125 MHz clock and APB byte addresses of four times the register index.
`ifndef HDC_DEFINES_VH
`define HDC_DEFINES_VH

// Register indices; byte address is four times the index
`define HDC_IDX_CTRL 12'h14b
`define HDC_IDX_MAN_LO 12'h14c
`define HDC_IDX_TRIP_LO 12'h14d
`define HDC_IDX_TRIP_HI 12'h14e
`define HDC_IDX_RATE_CNT 12'h14f
`define HDC_IDX_EVT_EN 12'h150
`define HDC_IDX_STATUS 12'h160
`define HDC_IDX_MASK 12'h161
`define HDC_IDX_TRACKED 12'h162

// Reset values
`define HDC_RST_CTRL 8'h16
`define HDC_RST_MAN_LO 8'h00
`define HDC_RST_TRIP_LO 8'h00
`define HDC_RST_TRIP_HI 8'h00
`define HDC_RST_RATE_CNT 8'h7f
`define HDC_RST_EVT_EN 8'h00
`define HDC_RST_MASK 6'h00
`define HDC_RST_DAC 10'h200

// Control register fields
`define HDC_F_TMO_HI 7
`define HDC_F_TMO_LO 6
`define HDC_F_IDLE_ON 5
`define HDC_F_FOLLOW 4
`define HDC_F_FORCE 3
`define HDC_F_FIXSEL 2
`define HDC_F_MANHI_HI 1
`define HDC_F_MANHI_LO 0
// Trip and rate fields
`define HDC_F_TRIP_HI 5
`define HDC_F_MULT_HI 7
`define HDC_F_MULT_LO 6
// Event enable fields
`define HDC_F_IDLE_KEEP 3
`define HDC_F_TRIP_WATCH 2

// Status bits
`define HDC_S_IDLE_LO 0
`define HDC_S_IDLE_HI 2
`define HDC_S_KEEP 3
`define HDC_S_TRIP_L 4
`define HDC_S_TRIP_H 5
`define HDC_NSTAT 6

// Idle timeout counts: one cycle per period of the threshold rate
`define HDC_CLK_KHZ 125000
`define HDC_TMO0_KHZ 370
`define HDC_TMO1_KHZ 2100
`define HDC_TMO2_KHZ 8800
`define HDC_TMO3_KHZ 22000
// Floor of clock rate over threshold rate, sized to the idle counter
`define HDC_TMO0_CYC 9'h151
`define HDC_TMO1_CYC 9'h03b
`define HDC_TMO2_CYC 9'h00e
`define HDC_TMO3_CYC 9'h005
`define HDC_TMO_W 9

// Tracking rate prescaler divisors
`define HDC_MULT0 14'h0004
`define HDC_MULT1 14'h0040
`define HDC_MULT2 14'h0400
`define HDC_MULT3 14'h4000
`define HDC_PRE_W 15

// Code and trip scale: one step of trip level is 1/64 of full scale
`define HDC_CODE_MAX 10'h3ff
`define HDC_TRIP_SHIFT 4
`define HDC_NREF 3

`endif

/* File: logic/hdc_track.v */
// DAC code follower with its update-rate divider.
// Assumes target is the digitised tuning voltage, synchronous to clk.
`include "hdc_defines.vh"

module hdc_track (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Rate setting
   input wire [1:0] mult_sel,
   input wire [7:0] rate_cnt,
   // Tracking
   input wire follow,
   input wire [9:0] target,
   output reg [9:0] code_r
);

reg [`HDC_PRE_W-1:0] pre_r;
reg [7:0] cnt_r;
reg [`HDC_PRE_W-1:0] pre_lim;
wire pre_tick;
wire tick;

always @* begin
   case (mult_sel)
      2'h0: pre_lim = {1'b0, `HDC_MULT0};
      2'h1: pre_lim = {1'b0, `HDC_MULT1};
      2'h2: pre_lim = {1'b0, `HDC_MULT2};
      default: pre_lim = {1'b0, `HDC_MULT3};
   endcase
end

assign pre_tick = (pre_r >= pre_lim - 1'b1);
// A zero count is taken as one
assign tick = pre_tick && (cnt_r + 8'h01 >= rate_cnt);

// Rate is multiplier times count clock cycles
always @(posedge clk) begin
   if (reset || !follow) begin
      pre_r <= {`HDC_PRE_W{1'b0}};
      cnt_r <= 8'h00;
   end else if (pre_tick) begin
      pre_r <= {`HDC_PRE_W{1'b0}};
      cnt_r <= tick ? 8'h00 : cnt_r + 8'h01;
   end else begin
      pre_r <= pre_r + 1'b1;
   end
end

// Starts mid-scale; steps one code toward target, never wraps
always @(posedge clk) begin
   if (reset) begin
      code_r <= `HDC_RST_DAC;
   end else if (follow && tick) begin
      if (target > code_r && code_r != `HDC_CODE_MAX)
         code_r <= code_r + 10'h001;
      else if (target < code_r && code_r != 10'h000)
         code_r <= code_r - 10'h001;
   end
end

endmodule // hdc_track

/* File: logic/hdc_top.v */
// Holdover DAC control register bank with APB slave, idle detection and DAC selection.
// Assumes all inputs synchronous to clk; APB3 master; registers one word each.
//
// Contract
// - Two-bit timeout selector 7:6 sets idle threshold 370k, 2.1M, 8.8M, 22 MHz.
// - Idle timeout only checked when idle detect bit 5 is one.
// - Idle timeout applies only to inputs marked single-ended CMOS.
// - Follow bit 4 makes the DAC code track the tuning voltage.
// - After reset the tracked code is 512.
// - Tracked code changes only while the first loop is locked.
// - Tracking works in every mode, not only holdover.
// - Force bit 3 enters holdover regardless of reference inputs.
// - Forced holdover drives manual code if selected, else the current tracked code.
// - Select bit 2: zero tracked code, one manual code.
// - Manual code is control bits 1:0 above low byte bits 7:0.
// - Manual code is plain binary 0 to 1023.
// - With trip watch on, holdover when voltage falls to (n+1)/64 of supply.
// - With trip watch on, holdover when voltage within (n+1)/64 of supply.
// - Tracking rate is multiplier 4/64/1024/16384 times eight-bit count.
// - Idle loss enters holdover only when its enable bit is one.
`include "hdc_defines.vh"

module hdc_top (
   // Clock and reset
   input wire clk,
   input wire reset,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [13:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Reference inputs
   input wire [`HDC_NREF-1:0] ref_input_edge,
   input wire [`HDC_NREF-1:0] ref_input_cmos,
   // First loop
   input wire first_loop_locked,
   input wire [9:0] tune_level,
   // Holdover and DAC
   output reg holdover_r,
   output reg [9:0] dac_code_r,
   output reg [`HDC_NREF-1:0] signal_absence_r,
   // Interrupt
   output reg irq_r
);

reg [7:0] ctrl_r;
reg [7:0] man_lo_r;
reg [7:0] trip_lo_r;
reg [7:0] trip_hi_r;
reg [7:0] rate_cnt_r;
reg [7:0] evt_en_r;
reg [`HDC_NSTAT-1:0] status_r;
reg [`HDC_NSTAT-1:0] status_nxt;
reg [`HDC_NSTAT-1:0] mask_r;
reg [31:0] rd_nxt;
reg hit_nxt;
reg [`HDC_TMO_W-1:0] tmo_lim;
reg hold_prev_r;
reg trip_lo_prev_r;
reg trip_hi_prev_r;

wire [11:0] idx;
wire wr_en;
wire [9:0] tracked_code;
wire [9:0] fixed_code_value;
wire fixed_code_select;
wire idle_detect_on;
wire follow_on;
wire trip_watch_on;
wire idle_triggers_keep;
wire [10:0] low_level;
wire [10:0] high_level;
wire trip_low;
wire trip_high;
wire any_absence;
wire hold_nxt;
wire [`HDC_NSTAT-1:0] evt;

// APB decode: word index from byte address
assign idx = paddr[13:2];
assign wr_en = psel && penable && pready && pwrite;

assign idle_detect_on = ctrl_r[`HDC_F_IDLE_ON];
assign follow_on = ctrl_r[`HDC_F_FOLLOW];
assign fixed_code_select = ctrl_r[`HDC_F_FIXSEL];
assign fixed_code_value = {ctrl_r[`HDC_F_MANHI_HI:`HDC_F_MANHI_LO], man_lo_r};
assign trip_watch_on = evt_en_r[`HDC_F_TRIP_WATCH];
assign idle_triggers_keep = evt_en_r[`HDC_F_IDLE_KEEP];

// Trip levels in code units: (n+1) sixty-fourths of full scale
assign low_level = {1'b0, trip_lo_r[`HDC_F_TRIP_HI:0] + 6'h00, `HDC_TRIP_SHIFT'h0} +
   {1'b0, 10'h010};
assign high_level = 11'h400 -
   ({1'b0, trip_hi_r[`HDC_F_TRIP_HI:0], `HDC_TRIP_SHIFT'h0} + 11'h010);
assign trip_low = trip_watch_on && ({1'b0, tune_level} <= low_level);
assign trip_high = trip_watch_on && ({1'b0, tune_level} >= high_level);

assign any_absence = |signal_absence_r;
assign hold_nxt = ctrl_r[`HDC_F_FORCE] ||
   (idle_triggers_keep && any_absence) ||
   trip_low || trip_high;

assign evt = {trip_high && !trip_hi_prev_r, trip_low && !trip_lo_prev_r,
   holdover_r && !hold_prev_r, signal_absence_r & ~{`HDC_NREF{1'b0}}};

// Timeout cycles for selected threshold
always @* begin
   case (ctrl_r[`HDC_F_TMO_HI:`HDC_F_TMO_LO])
      2'h0: tmo_lim = `HDC_TMO0_CYC;
      2'h1: tmo_lim = `HDC_TMO1_CYC;
      2'h2: tmo_lim = `HDC_TMO2_CYC;
      default: tmo_lim = `HDC_TMO3_CYC;
   endcase
end

// Per-input idle counter
genvar gi;
generate
   for (gi = 0; gi < `HDC_NREF; gi = gi + 1) begin : g_idle
      reg [`HDC_TMO_W-1:0] idle_cnt_r;
      always @(posedge clk) begin
         if (reset || !idle_detect_on || !ref_input_cmos[gi]) begin
            idle_cnt_r <= {`HDC_TMO_W{1'b0}};
            signal_absence_r[gi] <= 1'b0;
         end else if (ref_input_edge[gi]) begin
            idle_cnt_r <= {`HDC_TMO_W{1'b0}};
            signal_absence_r[gi] <= 1'b0;
         end else if (idle_cnt_r >= tmo_lim) begin
            signal_absence_r[gi] <= 1'b1;
         end else begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
         end
      end
   end
endgenerate

// Tracking runs in any mode, suspended without lock
hdc_track u_track (
   .clk(clk),
   .reset(reset),
   .mult_sel(trip_hi_r[`HDC_F_MULT_HI:`HDC_F_MULT_LO]),
   .rate_cnt(rate_cnt_r),
   .follow(follow_on && first_loop_locked),
   .target(tune_level),
   .code_r(tracked_code)
);

// Holdover state and DAC drive
always @(posedge clk) begin
   if (reset) begin
      holdover_r <= 1'b0;
      hold_prev_r <= 1'b0;
      trip_lo_prev_r <= 1'b0;
      trip_hi_prev_r <= 1'b0;
      dac_code_r <= `HDC_RST_DAC;
   end else begin
      holdover_r <= hold_nxt;
      hold_prev_r <= holdover_r;
      trip_lo_prev_r <= trip_low;
      trip_hi_prev_r <= trip_high;
      if (holdover_r && fixed_code_select)
         dac_code_r <= fixed_code_value;
      else
         dac_code_r <= tracked_code;
   end
end

// Configuration registers
always @(posedge clk) begin
   if (reset) begin
      ctrl_r <= `HDC_RST_CTRL;
      man_lo_r <= `HDC_RST_MAN_LO;
      trip_lo_r <= `HDC_RST_TRIP_LO;
      trip_hi_r <= `HDC_RST_TRIP_HI;
      rate_cnt_r <= `HDC_RST_RATE_CNT;
      evt_en_r <= `HDC_RST_EVT_EN;
      mask_r <= `HDC_RST_MASK;
   end else if (wr_en) begin
      case (idx)
         `HDC_IDX_CTRL: ctrl_r <= pwdata[7:0];
         `HDC_IDX_MAN_LO: man_lo_r <= pwdata[7:0];
         `HDC_IDX_TRIP_LO: trip_lo_r <= {2'b00, pwdata[`HDC_F_TRIP_HI:0]};
         `HDC_IDX_TRIP_HI: trip_hi_r <= pwdata[7:0];
         `HDC_IDX_RATE_CNT: rate_cnt_r <= pwdata[7:0];
         `HDC_IDX_EVT_EN: evt_en_r <= {4'h0, pwdata[3:2], 2'b00};
         `HDC_IDX_MASK: mask_r <= pwdata[`HDC_NSTAT-1:0];
         default: ;
      endcase
   end
end

// Sticky status, write one to clear, new event wins
always @* begin
   status_nxt = status_r;
   if (wr_en && idx == `HDC_IDX_STATUS)
      status_nxt = status_nxt & ~pwdata[`HDC_NSTAT-1:0];
   status_nxt = status_nxt | evt;
end

always @(posedge clk) begin
   if (reset) begin
      status_r <= {`HDC_NSTAT{1'b0}};
      irq_r <= 1'b0;
   end else begin
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
   end
end

// Read mux
always @* begin
   rd_nxt = 32'h0000_0000;
   hit_nxt = 1'b1;
   case (idx)
      `HDC_IDX_CTRL: rd_nxt[7:0] = ctrl_r;
      `HDC_IDX_MAN_LO: rd_nxt[7:0] = man_lo_r;
      `HDC_IDX_TRIP_LO: rd_nxt[7:0] = trip_lo_r;
      `HDC_IDX_TRIP_HI: rd_nxt[7:0] = trip_hi_r;
      `HDC_IDX_RATE_CNT: rd_nxt[7:0] = rate_cnt_r;
      `HDC_IDX_EVT_EN: rd_nxt[7:0] = evt_en_r;
      `HDC_IDX_STATUS: rd_nxt[`HDC_NSTAT-1:0] = status_r;
      `HDC_IDX_MASK: rd_nxt[`HDC_NSTAT-1:0] = mask_r;
      `HDC_IDX_TRACKED: rd_nxt[15:0] = {holdover_r, 5'h00, tracked_code};
      default: hit_nxt = 1'b0;
   endcase
end

// No wait state: answer prepared in setup cycle
always @(posedge clk) begin
   if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
   end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
         pslverr <= !hit_nxt;
         prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      end else begin
         pslverr <= 1'b0;
      end
   end
end

endmodule // hdc_top

/* File: testbench/hdc_top_properties.sv */
// Concurrent checks on the holdover DAC control top.
// Assumes binding to hdc_top; sees only its ports.
`include "hdc_defines.vh"

module hdc_top_check (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Bus
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   // Inputs
   input wire [`HDC_NREF-1:0] ref_input_edge,
   input wire [`HDC_NREF-1:0] ref_input_cmos,
   input wire first_loop_locked,
   // Outputs
   input wire holdover_r,
   input wire [9:0] dac_code_r,
   input wire [`HDC_NREF-1:0] signal_absence_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   a_ready_setup: assert property (psel && !penable |=> pready) else $error("no pready");
   a_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("stray pready");
   a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_reset_code: assert property ($past(reset) |-> dac_code_r == 10'h200 && !holdover_r)
      else $error("bad code after reset");
   a_code_frozen: assert property (
      !$past(first_loop_locked) && !$past(first_loop_locked, 2) && !$past(holdover_r)
      && !$past(holdover_r, 2) |-> $stable(dac_code_r)) else $error("code moved unlocked");
   a_code_step: assert property (
      !$past(holdover_r) && !$past(holdover_r, 2)
      |-> (dac_code_r - $past(dac_code_r)) inside {10'h000, 10'h001, 10'h3ff})
      else $error("code jumped");
   a_absence_cmos: assert property (signal_absence_r[0] |-> $past(ref_input_cmos[0]))
      else $error("absence on non-cmos");
   a_absence_clear: assert property (ref_input_edge[2] |-> ##[1:2] !signal_absence_r[2])
      else $error("absence kept after edge");
endmodule // hdc_top_check

bind hdc_top hdc_top_check u_check (.clk(clk), .reset(reset), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .ref_input_edge(ref_input_edge),
   .ref_input_cmos(ref_input_cmos), .first_loop_locked(first_loop_locked),
   .holdover_r(holdover_r), .dac_code_r(dac_code_r), .signal_absence_r(signal_absence_r));

/* File: testbench/hdc_top_tb.sv */
// Self-checking bench for the holdover DAC control top.
// Assumes hdc_top as APB slave; the bench drives every input itself.
`include "hdc_defines.vh"

module hdc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, first_loop_locked = 0, err;
   logic [13:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [2:0] ref_input_edge = 0, ref_input_cmos = 0;
   logic [9:0] tune_level = 0, m_code;
   wire [31:0] prdata;
   wire pready, pslverr, holdover_r, irq_r;
   wire [9:0] dac_code_r;
   wire [2:0] signal_absence_r;
   int fail_count = 0, n_compared = 0, cyc = 0, m_trk = 512, n;
   int khz[4] = '{370, 2100, 8800, 22000};
   logic [11:0] ridx[6] = '{12'h14b, 12'h14c, 12'h14d, 12'h14e, 12'h14f, 12'h162};
   logic [31:0] rexp[6] = '{32'h16, 32'h0, 32'h0, 32'h0, 32'h7f, 32'h200};
   int tv[5] = '{520, 0, 0, 1023, 0}, lk[5] = '{1, 0, 1, 1, 1};
   int fo[5] = '{16, 16, 0, 16, 16}, wt[5] = '{100, 100, 100, 2200, 4200};

   always #4 clk = ~clk;

   hdc_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_input_edge(ref_input_edge), .ref_input_cmos(ref_input_cmos),
      .first_loop_locked(first_loop_locked), .tune_level(tune_level),
      .holdover_r(holdover_r), .dac_code_r(dac_code_r), .signal_absence_r(signal_absence_r),
      .irq_r(irq_r));

   task automatic give_verdict;
      if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   // One APB transfer; waits for pready
   task automatic apb(logic w, logic [11:0] idx, logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      rd = $urandom(32'h65db);
      repeat (12) @(posedge clk);
      reset <= 0;
      for (int i = 0; i < 6; i++) begin
         apb(0, ridx[i], 0);
         chk("reset value", rexp[i], rd);
      end
      chk("dac after reset", 32'h200, dac_code_r);
      apb(0, 12'h170, 0);
      chk("unmapped error", 1, err);
      chk("unmapped data", 0, rd);
      // Forced holdover with fixed code, edge values first
      for (int i = 0; i < 4; i++) begin
         m_code = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($urandom);
         apb(1, 12'h14c, {24'h0, m_code[7:0]});
         apb(1, 12'h14b, {24'h0, 6'h03, m_code[9:8]});
         repeat (3) @(posedge clk);
         chk("forced holdover", 1, holdover_r);
         chk("fixed code", m_code, dac_code_r);
      end
      apb(1, 12'h14b, 32'h08);
      repeat (3) @(posedge clk);
      chk("tracked in holdover", m_trk, dac_code_r);
      apb(1, 12'h14b, 32'h0);
      repeat (3) @(posedge clk);
      chk("holdover off", 0, holdover_r);
      // Tracking: lock, unlock, disable, clamp at both ends
      apb(1, 12'h14f, 32'h1);
      for (int i = 0; i < 5; i++) begin
         tune_level <= 10'(tv[i]);
         first_loop_locked <= lk[i][0];
         apb(1, 12'h14b, fo[i]);
         repeat (wt[i]) @(posedge clk);
         if (lk[i] != 0 && fo[i] != 0) m_trk = tv[i];
         chk("tracked code", m_trk, dac_code_r);
      end
      apb(0, 12'h162, 0);
      chk("tracked readback", m_trk, rd);
      // Idle timeout per selector code
      ref_input_cmos <= 3'b101;
      apb(1, 12'h160, 32'h3f);
      for (int s = 0; s < 4; s++) begin
         apb(1, 12'h14b, {24'h0, s[1:0], 6'h20});
         ref_input_edge <= 3'b111;
         @(posedge clk);
         ref_input_edge <= 3'b000;
         repeat (125000 / khz[s] - 1) @(posedge clk);
         chk("absence early", 0, signal_absence_r);
         repeat (4) @(posedge clk);
         chk("absence", 32'h5, signal_absence_r);
         apb(1, 12'h14b, 32'h0);
         repeat (400) @(posedge clk);
         chk("absence disabled", 0, signal_absence_r);
      end
      // Interrupt mask and clear
      chk("irq masked", 0, irq_r);
      apb(0, 12'h160, 0);
      chk("status", 32'h5, rd);
      apb(1, 12'h161, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq raised", 1, irq_r);
      apb(1, 12'h160, 32'h1);
      @(posedge clk);
      chk("irq cleared", 0, irq_r);
      apb(0, 12'h160, 0);
      chk("status left", 32'h4, rd);
      // Lower trip level at its boundary
      apb(1, 12'h14d, 32'hff);
      apb(0, 12'h14d, 0);
      chk("trip field", 32'h3f, rd);
      n = $urandom_range(55);
      apb(1, 12'h14d, n);
      apb(1, 12'h150, 32'h4);
      tune_level <= 10'((n + 1) * 16);
      repeat (3) @(posedge clk);
      chk("trip holdover", 1, holdover_r);
      tune_level <= 10'((n + 1) * 16 + 1);
      repeat (3) @(posedge clk);
      chk("above trip", 0, holdover_r);
      // Upper trip level at its boundary
      apb(1, 12'h14d, 0);
      apb(1, 12'h14e, n);
      tune_level <= 10'(1024 - (n + 1) * 16);
      repeat (3) @(posedge clk);
      chk("high trip holdover", 1, holdover_r);
      tune_level <= 10'(1023 - (n + 1) * 16);
      repeat (3) @(posedge clk);
      chk("below high trip", 0, holdover_r);
      // Idle loss enters holdover only when enabled
      apb(1, 12'h150, 32'h8);
      apb(1, 12'h14b, 32'he0);
      repeat (20) @(posedge clk);
      chk("idle holdover", 1, holdover_r);
      apb(1, 12'h150, 32'h0);
      repeat (3) @(posedge clk);
      chk("idle no holdover", 0, holdover_r);
      give_verdict();
   end
endmodule // hdc_top_tb
